// File: src/isl_pkg.sv
// Purpose: Shared constants and types for the two-wire slave engine
// Assumes: 10 MHz core clock, 8-bit register port
// Notes: Register offsets of both ends live here
package isl_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int QUARTER_NS = 1000;   // Master bus-clock quarter period
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------
  // Slave register map
  // ----------------------------------------
  localparam logic [2:0] S_CTRL = 3'h0;  // port_control_one
  localparam logic [2:0] S_STAT = 3'h1;  // port_status_reg
  localparam logic [2:0] S_BUF = 3'h2;   // rx_tx_buffer
  localparam logic [2:0] S_OWN = 3'h3;   // own_address_reg
  localparam logic [2:0] S_IRQ = 3'h4;   // peripheral_irq_reg_two
  localparam int CTRL_TEN = 0;
  localparam int CTRL_CKP = 4;
  localparam int CTRL_EN = 5;
  localparam int CTRL_OV = 6;
  localparam int STAT_BF = 0;
  localparam int STAT_UA = 1;
  localparam int STAT_RW = 2;
  localparam int IRQ_FLAG = 7;
  localparam logic [4:0] TEN_MARK = 5'h1e;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;
  localparam logic [7:0] ALL_ONES = 8'hff;
  // ----------------------------------------
  // Master register map and commands
  // ----------------------------------------
  localparam logic [2:0] M_CMD = 3'h0;
  localparam logic [2:0] M_TXD = 3'h1;
  localparam logic [2:0] M_STAT = 3'h2;
  localparam logic [2:0] M_RXD = 3'h3;
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_STOP = 2'h3;
  localparam int CMD_NACK = 2;
  localparam int MST_BUSY = 0;
  localparam int MST_ACK = 1;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [2:0] isl_ra_t;
  typedef logic [7:0] isl_byte_t;
  typedef enum logic [1:0] {SL_IDLE, SL_RX, SL_TX} isl_sst_t;
  typedef enum logic [1:0] {PH_A1, PH_A2, PH_DATA} isl_ph_t;
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} isl_mst_t;
endpackage

// File: src/isl_if.sv
// Purpose: Open-drain two-wire bus joining slave and master ends
// Assumes: Each end drives only low; enables are active low
// Notes: Wired-AND with pull-up is resolved here
`timescale 1ns/10ps
`default_nettype none
interface isl_if;
  logic sSclO, sSclOeN, sSdaO, sSdaOeN;
  logic mSclO, mSclOeN, mSdaO, mSdaOeN;
  logic sclLine, sdaLine;
  // Pull-up wins unless some end drives
  assign sclLine = (sSclOeN | sSclO) & (mSclOeN | mSclO);
  assign sdaLine = (sSdaOeN | sSdaO) & (mSdaOeN | mSdaO);
  modport dev (input sclLine, sdaLine,
               output sSclO, sSclOeN, sSdaO, sSdaOeN);
  modport ctl (input sclLine, sdaLine,
               output mSclO, mSclOeN, mSdaO, mSdaOeN);
endinterface
`default_nettype wire

// File: src/isl_sync.sv
// Purpose: Two-flop synchroniser for the clock and data lines
// Assumes: Lines idle high
// Notes: Stage one feeds stage two only
`timescale 1ns/10ps
`default_nettype none
module isl_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] din,
  output logic [1:0] dout
);
  import isl_pkg::*;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } isl_sy_t;
  isl_sy_t r, n;
  // Shift both stages
  always_comb begin
    n = r;
    n.s1 = din;
    n.s2 = r.s1;
  end
  // Idle-high reset keeps edge finders quiet
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '1;
    end else begin
      r <= n;
    end
  end
  assign dout = r.s2;
endmodule
`default_nettype wire

// File: src/isl_slave.sv
// Purpose: Slave end of the two-wire port with double-buffered receive
// Assumes: Bus master drives the clock; lines pass a two-flop sync
// Notes: Registers reached over a plain address/strobe port
// Summary of operation
// - Full byte moves to buffer, flag set
// - Byte over full buffer sets overflow, dropped
// - Software loads high pattern, then low byte
// - Match or data byte: auto acknowledge, load
// - No acknowledge if full or overflow set
// - Full buffer: keep buffer, set flag, overflow
// - Overflow only: load buffer, flag, no acknowledge
// - Buffer read clears full; software clears overflow
// - After start, shift eight bits on rises
// - Compare bits 7:1 on eighth falling edge
// - Load and full on eighth; flag ninth
// - Ten-bit marker in top five bits
// - Ten-bit byte sets update, holds clock
// - Repeated start: first byte match only
// - Write direction clears direction status bit
// - Flag raised per byte, cleared by software
// - Read direction: set status, acknowledge, hold
// - Buffer write loads shifter; release bit frees
// - Transmit bits change on falling edges
// - Master not-acknowledge returns to idle
// - Transmit flag set on ninth falling edge
// - Master waits while clock held low
// - Port works only while enabled
`timescale 1ns/10ps
`default_nettype none
module isl_slave (
  input wire logic core_clk,
  input wire logic rst_n,
  isl_if.dev bus,
  input wire isl_pkg::isl_ra_t regAddr,
  input wire isl_pkg::isl_byte_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata
);
  import isl_pkg::*;
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    isl_sst_t st;
    isl_ph_t ph;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic [7:0] rxBuf;
    logic [7:0] own;
    logic en, ten, clock_release_bit, ov, bf, ua, rw, irq;
    logic ack, tenDone, goTx;
    logic sclP, sdaP;
    logic sclOeN, sdaOeN;
    logic [7:0] rdata;
  } isl_sl_t;
  isl_sl_t r, n;
  logic [1:0] lineS;
  logic sclS, sdaS, sclRise, sclFall, startEv, stopEv, hit;
  // ----------------------------------------
  // Line sampling
  // ----------------------------------------
  isl_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din({bus.sclLine, bus.sdaLine}),
    .dout(lineS)
  );
  // Edges seen on synchronised lines only
  assign sclS = lineS[1];
  assign sdaS = lineS[0];
  assign sclRise = sclS & ~r.sclP;
  assign sclFall = ~sclS & r.sclP;
  assign startEv = ~sdaS & r.sdaP & sclS & r.sclP;
  assign stopEv = sdaS & ~r.sdaP & sclS & r.sclP;
  // Address compare; own register holds address in bits 7:1
  always_comb begin
    hit = 1'b1;
    unique case (r.ph)
      PH_A1: hit = (r.sr[7:1] == r.own[7:1]) &&
                   (!r.ten || r.sr[7:3] == TEN_MARK);
      PH_A2: hit = (r.sr == r.own);
      PH_DATA: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.rdata = 8'h00;
    n.sclP = sclS;
    n.sdaP = sdaS;
    // Software writes first so hardware sets win below
    if (regWr) begin
      unique case (regAddr)
        S_CTRL: begin
          n.ten = regWdata[CTRL_TEN];
          n.clock_release_bit = regWdata[CTRL_CKP];
          n.en = regWdata[CTRL_EN];
          n.ov = regWdata[CTRL_OV];
        end
        S_BUF: begin
          n.rxBuf = regWdata;
          if (r.st == SL_TX) begin
            n.sr = regWdata;
          end
        end
        S_OWN: begin
          n.own = regWdata;
          n.ua = 1'b0;
        end
        S_IRQ: n.irq = regWdata[IRQ_FLAG];
        default: ;
      endcase
    end
    if (regRd) begin
      unique case (regAddr)
        S_CTRL: begin
          n.rdata[CTRL_TEN] = r.ten;
          n.rdata[CTRL_CKP] = r.clock_release_bit;
          n.rdata[CTRL_EN] = r.en;
          n.rdata[CTRL_OV] = r.ov;
        end
        S_STAT: begin
          n.rdata[STAT_BF] = r.bf;
          n.rdata[STAT_UA] = r.ua;
          n.rdata[STAT_RW] = r.rw;
        end
        S_BUF: begin
          n.rdata = r.rxBuf;
          n.bf = 1'b0;
        end
        S_OWN: n.rdata = r.own;
        S_IRQ: n.rdata[IRQ_FLAG] = r.irq;
        default: ;
      endcase
    end
    // Bus side; a disable aborts any transfer
    // idle unless enabled
    if (!r.en) begin
      n.st = SL_IDLE;
      n.tenDone = 1'b0;
    end else if (startEv) begin
      n.st = SL_RX;
      n.ph = PH_A1;
      n.cnt = 4'h0;
      n.goTx = 1'b0;
    end else if (stopEv) begin
      n.st = SL_IDLE;
      n.tenDone = 1'b0;
    end else begin
      unique case (r.st)
        SL_IDLE: ;
        SL_RX: begin
          if (sclRise && r.cnt < ACK_BIT) begin
            if (r.cnt < BYTE_BITS) begin
              n.sr = {r.sr[6:0], sdaS};
            end
            n.cnt = r.cnt + 4'h1;
          end
          if (sclFall && r.cnt == BYTE_BITS) begin
            if (!hit) begin
              n.st = SL_IDLE;
            end else begin
              n.ack = !r.bf && !r.ov;
              n.sdaOeN = !(!r.bf && !r.ov);
              if (!r.bf) begin
                n.rxBuf = r.sr;
                n.bf = 1'b1;
              end else begin
                n.ov = 1'b1;
              end
              if (r.ph == PH_A1) begin
                n.rw = r.sr[0];
                if (r.ten && !r.tenDone) begin
                  n.ua = 1'b1;
                  n.ph = PH_A2;
                end else begin
                  n.ph = PH_DATA;
                  n.goTx = r.sr[0];
                end
              end else if (r.ph == PH_A2) begin
                n.ua = 1'b1;
                n.ph = PH_DATA;
                n.tenDone = 1'b1;
              end
            end
          end
          if (sclFall && r.cnt == ACK_BIT) begin
            n.sdaOeN = 1'b1;
            n.cnt = 4'h0;
            n.irq = 1'b1;
            if (r.goTx) begin
              n.st = SL_TX;
              n.clock_release_bit = 1'b0;
              n.sclOeN = 1'b0;
              n.goTx = 1'b0;
              n.sr = ALL_ONES;
            end else if (r.ua) begin
              n.sclOeN = 1'b0;
            end
          end
        end
        SL_TX: begin
          if (sclRise && r.cnt < ACK_BIT) begin
            n.cnt = r.cnt + 4'h1;
            // latch master acknowledge on ninth rise
            if (r.cnt == BYTE_BITS) begin
              n.ack = !sdaS;
            end
          end
          if (sclFall && r.cnt != 4'h0 && r.cnt < ACK_BIT) begin
            n.sr = {r.sr[6:0], 1'b1};
          end
          if (sclFall && r.cnt == ACK_BIT) begin
            // flag every byte; stretch only after acknowledge
            n.irq = 1'b1;
            n.cnt = 4'h0;
            n.clock_release_bit = 1'b0;
            n.sclOeN = !r.ack;
            // not-acknowledge: back to waiting for start
            n.st = r.ack ? SL_TX : SL_IDLE;
          end
        end
        default: n.st = SL_IDLE;
      endcase
    end
    // Line drive follows state; ones in shifter release the line
    // release bit ends transmit stretch
    if (n.st == SL_TX) begin
      n.sdaOeN = n.sr[7];
      if (n.clock_release_bit) begin
        n.sclOeN = 1'b1;
      end
    end else if (n.st == SL_RX && !n.ua && !r.goTx) begin
      n.sclOeN = 1'b1;
    end else if (n.st == SL_IDLE) begin
      n.sclOeN = 1'b1;
      n.sdaOeN = 1'b1;
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Lines released from reset on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.sclP <= 1'b1;
      r.sdaP <= 1'b1;
      r.sclOeN <= 1'b1;
      r.sdaOeN <= 1'b1;
    end else begin
      r <= n;
    end
  end
  assign bus.sSclO = 1'b0;
  assign bus.sSdaO = 1'b0;
  assign bus.sSclOeN = r.sclOeN;
  assign bus.sSdaOeN = r.sdaOeN;
  assign regRdata = r.rdata;
endmodule
`default_nettype wire

// File: src/isl_master.sv
// Purpose: Bus-master end issuing start, byte, and stop commands
// Assumes: One command at a time, polled through the busy bit
// Notes: Honours clock stretching before each high phase
`timescale 1ns/10ps
`default_nettype none
module isl_master (
  input wire logic core_clk,
  input wire logic rst_n,
  isl_if.ctl bus,
  input wire isl_pkg::isl_ra_t regAddr,
  input wire isl_pkg::isl_byte_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata
);
  import isl_pkg::*;
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    isl_mst_t st;
    logic [1:0] q;
    logic [3:0] div;
    logic [3:0] bitIdx;
    logic [7:0] sh;
    logic [1:0] op;
    logic nack, ackSeen;
    logic [7:0] txd, rxd;
    logic sclOeN, sdaOeN;
    logic [7:0] rdata;
  } isl_ms_t;
  isl_ms_t r, n;
  logic [1:0] lineS;
  logic tick;
  isl_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din({bus.sclLine, bus.sdaLine}),
    .dout(lineS)
  );
  // Quarter-bit enable from divider
  assign tick = (r.div == 4'(QUARTER_CYC - 1));
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.rdata = 8'h00;
    n.div = tick ? 4'h0 : r.div + 4'h1;
    if (regWr && regAddr == M_TXD) begin
      n.txd = regWdata;
    end
    // Commands while busy are ignored
    if (regWr && regAddr == M_CMD && r.st == MS_IDLE) begin
      n.op = regWdata[1:0];
      n.nack = regWdata[CMD_NACK];
      n.q = 2'h0;
      n.div = 4'h0;
      n.bitIdx = 4'h0;
      n.sh = (regWdata[1:0] == OP_READ) ? ALL_ONES : r.txd;
      unique case (regWdata[1:0])
        OP_START: n.st = MS_START;
        OP_STOP: n.st = MS_STOP;
        default: n.st = MS_BIT;
      endcase
    end
    if (regRd) begin
      unique case (regAddr)
        M_TXD: n.rdata = r.txd;
        M_STAT: begin
          n.rdata[MST_BUSY] = (r.st != MS_IDLE);
          n.rdata[MST_ACK] = r.ackSeen;
        end
        M_RXD: n.rdata = r.rxd;
        default: ;
      endcase
    end
    if (tick) begin
      unique case (r.st)
        MS_IDLE: ;
        MS_START: begin
          unique case (r.q)
            2'h0: n.sdaOeN = 1'b1;
            2'h1: n.sclOeN = 1'b1;
            2'h2: n.sdaOeN = !lineS[1];
            2'h3: begin
              n.sclOeN = 1'b0;
              n.st = MS_IDLE;
            end
          endcase
          if (r.q != 2'h2 || lineS[1]) begin
            n.q = r.q + 2'h1;
          end
        end
        MS_STOP: begin
          unique case (r.q)
            2'h0: begin
              n.sclOeN = 1'b0;
              n.sdaOeN = 1'b0;
            end
            2'h1: n.sclOeN = 1'b1;
            2'h2: ;
            2'h3: begin
              n.sdaOeN = 1'b1;
              n.st = MS_IDLE;
            end
          endcase
          if (r.q != 2'h2 || lineS[1]) begin
            n.q = r.q + 2'h1;
          end
        end
        MS_BIT: begin
          unique case (r.q)
            2'h0: begin
              n.sclOeN = 1'b0;
              if (r.bitIdx < BYTE_BITS) begin
                n.sdaOeN = r.sh[7];
              end else begin
                n.sdaOeN = (r.op == OP_WRITE) ? 1'b1 : r.nack;
              end
            end
            2'h1: n.sclOeN = 1'b1;
            2'h2: if (lineS[1]) begin
              if (r.bitIdx < BYTE_BITS) begin
                n.sh = {r.sh[6:0], lineS[0]};
              end else if (r.op == OP_WRITE) begin
                n.ackSeen = !lineS[0];
              end
            end
            2'h3: begin
              n.sclOeN = 1'b0;
              if (r.bitIdx == BYTE_BITS) begin
                n.st = MS_IDLE;
                n.rxd = r.sh;
              end else begin
                n.bitIdx = r.bitIdx + 4'h1;
              end
            end
          endcase
          if (r.q != 2'h2 || lineS[1]) begin
            n.q = r.q + 2'h1;
          end
        end
        default: n.st = MS_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.sclOeN <= 1'b1;
      r.sdaOeN <= 1'b1;
    end else begin
      r <= n;
    end
  end
  assign bus.mSclO = 1'b0;
  assign bus.mSdaO = 1'b0;
  assign bus.mSclOeN = r.sclOeN;
  assign bus.mSdaOeN = r.sdaOeN;
  assign regRdata = r.rdata;
endmodule
`default_nettype wire

// File: tb/isl_assertions.sv
// Purpose: Wire-level checks on the open-drain link between both ends
// Assumes: One clock domain; lines resolved inside the interface
// Notes: Sync latency lets the slave act a few cycles after an edge
`timescale 1ns/10ps
`default_nettype none
module isl_assertions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sSclO,
  input wire logic sSclOeN,
  input wire logic sSdaO,
  input wire logic sSdaOeN,
  input wire logic mSclO,
  input wire logic mSclOeN,
  input wire logic mSdaO,
  input wire logic sclLine
);
  // ----------------------------------------
  // Clocking and sequences
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Slave already pulling data when the clock goes high
  sequence s_ackHigh;
    $rose(sclLine) && !sSdaOeN;
  endsequence
  // Pull kept through the early high phase
  sequence s_heldLow;
    !sSdaOeN [*5];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_scl_low_only: assert property (!sSclO)
    else $error("slave clock output not low");
  a_sda_low_only: assert property (!sSdaO)
    else $error("slave data output not low");
  a_master_low_only: assert property (!mSclO && !mSdaO)
    else $error("master output not low");
  a_ack_spans_high: assert property (s_ackHigh |-> s_heldLow)
    else $error("slave data pull dropped in clock high");
  // A new drive only follows a settled clock fall
  a_drive_after_fall: assert property ($fell(sSdaOeN) |->
    !sclLine && !$past(sclLine, 2))
    else $error("slave data drive not after clock fall");
  a_release_while_low: assert property ($rose(sSdaOeN) |-> !sclLine)
    else $error("slave data release during clock high");
  a_hold_starts_low: assert property ($fell(sSclOeN) |->
    !sclLine && !$past(sclLine))
    else $error("slave clock hold not after a fall");
  a_master_waits: assert property ((mSclOeN && !sSclOeN && !sclLine)
    |=> mSclOeN)
    else $error("master pulled clock during stretch");
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench joining slave and master ends
// Assumes: Both register ports driven here; master makes the bus clock
// Notes: Address cases run from a table; overflow, read and ten-bit by hand
`timescale 1ns/10ps
`default_nettype none
module tb;
  import isl_pkg::*;
  typedef struct packed {
    isl_byte_t ctrl;
    isl_byte_t own;
    isl_byte_t adr;
    logic ack;
  } isl_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  isl_ra_t addr = 3'h0;
  isl_byte_t wdat = 8'h00;
  logic [1:0] wr = 2'b00;
  logic [1:0] rd = 2'b00;
  logic [7:0] sRdata, mRdata, rdv;
  int miscompares = 0;
  int n_tests = 0;
  isl_row_t rows [6] = '{'{8'h20, 8'h84, 8'h84, 1'b1},
    '{8'h20, 8'h84, 8'h86, 1'b0}, '{8'h00, 8'h84, 8'h84, 1'b0},
    '{8'h20, 8'h85, 8'h84, 1'b1}, '{8'h20, 8'hfe, 8'hfe, 1'b1},
    '{8'h20, 8'h84, 8'h04, 1'b0}};
  // ----------------------------------------
  // Structure
  // ----------------------------------------
  isl_if busIf ();
  isl_slave isl_slave_i (.core_clk(core_clk), .rst_n(rst_n), .bus(busIf),
    .regAddr(addr), .regWdata(wdat), .regWr(wr[0]), .regRd(rd[0]),
    .regRdata(sRdata));
  isl_master isl_master_i (.core_clk(core_clk), .rst_n(rst_n), .bus(busIf),
    .regAddr(addr), .regWdata(wdat), .regWr(wr[1]), .regRd(rd[1]),
    .regRdata(mRdata));
  isl_assertions isl_assertions_i (.core_clk(core_clk), .rst_n(rst_n),
    .sSclO(busIf.sSclO), .sSclOeN(busIf.sSclOeN), .sSdaO(busIf.sSdaO),
    .sSdaOeN(busIf.sSdaOeN), .mSclO(busIf.mSclO), .mSclOeN(busIf.mSclOeN),
    .mSdaO(busIf.mSdaO), .sclLine(busIf.sclLine));
  // 10 MHz clock
  always #50 core_clk = ~core_clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One strobe cycle on end e (0 slave, 1 master); read data lands in rdv
  task automatic acc(input int e, input logic w, input isl_ra_t a,
                     input isl_byte_t d);
    @(posedge core_clk);
    addr <= a;
    wdat <= d;
    wr[e] <= w;
    rd[e] <= !w;
    @(posedge core_clk);
    wr <= 2'b00;
    rd <= 2'b00;
    #1 rdv = e ? mRdata : sRdata;
  endtask
  // Bounded busy poll; a stuck master counts as a mismatch
  task automatic mop(input logic [1:0] op, input logic nk);
    int k;
    acc(1, 1'b1, M_CMD, {5'h00, nk, op});
    for (k = 0; k < 3000; k++) begin
      acc(1, 1'b0, M_STAT, 8'h00);
      if (rdv[MST_BUSY] === 1'b0) break;
    end
    if (k == 3000) chk(8'h01, 8'h00);
  endtask
  task automatic mtx(input isl_byte_t b, input logic ack);
    acc(1, 1'b1, M_TXD, b);
    mop(OP_WRITE, 1'b0);
    chk(8'(rdv[MST_ACK]), 8'(ack));
  endtask
  task automatic sget(input isl_ra_t a, input isl_byte_t exp);
    acc(0, 1'b0, a, 8'h00);
    chk(rdv, exp);
  endtask
  // Slave loads the transmit byte, releases the clock, master reads it
  task automatic sendBack(input isl_byte_t b, input logic nk);
    acc(0, 1'b1, S_BUF, b);
    acc(0, 1'b1, S_CTRL, 8'h30);
    mop(OP_READ, nk);
    sget(S_STAT, 8'h04);
    acc(1, 1'b0, M_RXD, 8'h00);
    chk(rdv, b);
    sget(S_IRQ, 8'h80);
    acc(0, 1'b1, S_IRQ, 8'h00);
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #(100000 * 100);
    miscompares++;
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    sget(S_CTRL, 8'h00);
    chk(8'({busIf.sclLine, busIf.sdaLine}), 8'h03);
    acc(0, 1'b1, 3'h7, 8'hff);
    sget(3'h7, 8'h00);
    // Address matching, enable and acknowledge cases
    foreach (rows[i]) begin
      acc(0, 1'b1, S_CTRL, rows[i].ctrl);
      acc(0, 1'b1, S_OWN, rows[i].own);
      mop(OP_START, 1'b0);
      mtx(rows[i].adr, rows[i].ack);
      sget(S_STAT, 8'(rows[i].ack));
      sget(S_IRQ, {rows[i].ack, 7'h00});
      acc(0, 1'b0, S_BUF, 8'h00);
      if (rows[i].ack) chk(rdv, rows[i].adr);
      sget(S_STAT, 8'h00);
      acc(0, 1'b1, S_IRQ, 8'h00);
      sget(S_IRQ, 8'h00);
      mop(OP_STOP, 1'b0);
    end
    // Double buffering, overflow and recovery
    mop(OP_START, 1'b0);
    mtx(8'h84, 1'b1);
    acc(0, 1'b0, S_BUF, 8'h00);
    mtx(8'h5a, 1'b1);
    mtx(8'hc3, 1'b0);
    sget(S_CTRL, 8'h60);
    sget(S_BUF, 8'h5a);
    acc(0, 1'b1, S_IRQ, 8'h00);
    mtx(8'h3c, 1'b0);
    sget(S_IRQ, 8'h80);
    sget(S_BUF, 8'h3c);
    sget(S_CTRL, 8'h60);
    acc(0, 1'b1, S_CTRL, 8'h20);
    sget(S_CTRL, 8'h20);
    mtx(8'h96, 1'b1);
    sget(S_BUF, 8'h96);
    mop(OP_STOP, 1'b0);
    // Slave transmit: ack then not-ack ends the transfer
    acc(0, 1'b1, S_IRQ, 8'h00);
    mop(OP_START, 1'b0);
    mtx(8'h85, 1'b1);
    sget(S_STAT, 8'h05);
    sget(S_BUF, 8'h85);
    acc(0, 1'b1, S_IRQ, 8'h00);
    sendBack(8'ha5, 1'b0);
    sendBack(8'h3c, 1'b1);
    mop(OP_STOP, 1'b0);
    mop(OP_START, 1'b0);
    mtx(8'h84, 1'b1);
    acc(0, 1'b0, S_BUF, 8'h00);
    mop(OP_STOP, 1'b0);
    // Ten-bit address with update handshake and repeated start
    acc(0, 1'b1, S_CTRL, 8'h21);
    acc(0, 1'b1, S_OWN, 8'hf2);
    mop(OP_START, 1'b0);
    mtx(8'hf2, 1'b1);
    sget(S_STAT, 8'h03);
    acc(0, 1'b1, S_OWN, 8'h34);
    sget(S_STAT, 8'h01);
    sget(S_BUF, 8'hf2);
    mtx(8'h34, 1'b1);
    sget(S_STAT, 8'h03);
    sget(S_BUF, 8'h34);
    acc(0, 1'b1, S_OWN, 8'hf2);
    mtx(8'h77, 1'b1);
    sget(S_BUF, 8'h77);
    acc(0, 1'b1, S_IRQ, 8'h00);
    mop(OP_START, 1'b0);
    mtx(8'hf3, 1'b1);
    sget(S_STAT, 8'h05);
    sget(S_IRQ, 8'h80);
    acc(0, 1'b1, S_IRQ, 8'h00);
    acc(0, 1'b0, S_BUF, 8'h00);
    acc(0, 1'b1, S_BUF, 8'h11);
    acc(0, 1'b1, S_CTRL, 8'h31);
    mop(OP_READ, 1'b1);
    acc(1, 1'b0, M_RXD, 8'h00);
    chk(rdv, 8'h11);
    mop(OP_STOP, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
